/* File: src/oicq_regs.svh */
`ifndef OICQ_REGS_SVH
`define OICQ_REGS_SVH
// Register byte offsets
`define OICQ_CTRL        8'h00
`define OICQ_STATUS      8'h04
`define OICQ_MASK        8'h08
`define OICQ_OCC         8'h0c
`define OICQ_POLICY0     8'h10
`define OICQ_MAP0        8'h20
`define OICQ_THR0        8'h38
`define OICQ_RATE0       8'h44
`define OICQ_CNT0        8'h80
// Field positions
`define OICQ_CTRL_EN     0
`define OICQ_CTRL_NETCTL 1
`define OICQ_POL_TOPDSCP 3
`define OICQ_EV_RATE     3
// Reset values
`define OICQ_CTRL_RST    32'h0000_0003
`define OICQ_MAP_LO_RST  32'h4567_89ab
`define OICQ_MAP_HI_RST  32'h0011_2233
`define OICQ_THR_RST     32'h100c_0804
`define OICQ_RATE_RST    32'h0000_4010
// Classes and sizes
`define OICQ_CLS_NETCTL  4'h0
`define OICQ_CLS_BEST    4'hf
`define OICQ_PORTS       4
`define OICQ_QUEUES      3
`define OICQ_CLASSES     16
`define OICQ_QDEPTH      5'h10
`define OICQ_CNT_MAX     16'hffff
// Timing
`define OICQ_CLK_MHZ     200
`define OICQ_REFRESH_NS  1000
`define OICQ_REFRESH_CYC ((`OICQ_REFRESH_NS * `OICQ_CLK_MHZ) / 1000)
`endif

/* File: src/oicq_pkg.sv */
package oicq_pkg;
   // Classification type chosen by the access point's policy
   typedef enum logic [2:0] {
      MODE_DEFAULT,
      MODE_VLAN,
      MODE_DSCP,
      MODE_MIXED,
      MODE_FILTER
   } oicq_mode_t;
   typedef logic [3:0] oicq_cls_t;
   typedef logic [1:0] oicq_qid_t;
endpackage

/* File: src/oicq_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module oicq_mem (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        we,
   input  wire logic [5:0]  waddr,
   input  wire logic [31:0] wdata,
   input  wire logic        re,
   input  wire logic [5:0]  raddr,
   output logic [31:0]      rdata
);
   logic [31:0] mem_reg [64];
   logic [31:0] rdata_reg;

   // Storage has no reset, contents only matter once written
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_reg[waddr] <= wdata;
      end
   end

   // Registered read port
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_reg <= 32'h0000_0000;
      end else if (re) begin
         rdata_reg <= mem_reg[raddr];
      end
   end

   assign rdata = rdata_reg;
endmodule
`default_nettype wire

/* File: src/oicq_rate.sv */
`timescale 1ns/100ps
`default_nettype none
module oicq_rate (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       tick,
   input  wire logic [7:0] rate,
   input  wire logic [7:0] burst,
   input  wire logic       take,
   output logic            ok,
   output logic            pause
);
   logic [7:0] bucket_reg;
   logic [7:0] bucket_next;
   logic [8:0] fill_sum;
   logic [7:0] base;
   logic       pause_reg;

   // Token bucket, one token per packet, refilled each tick
   always_comb begin
      fill_sum = {1'b0, bucket_reg} + {1'b0, rate};
      base = bucket_reg;
      if (tick) begin
         base = (fill_sum > {1'b0, burst}) ? burst : fill_sum[7:0];
      end
      bucket_next = base;
      if (take && ok && base != 8'h00) begin
         bucket_next = base - 8'h01;
      end
   end

   assign ok = bucket_reg != 8'h00;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bucket_reg <= 8'h00;
      end else if (ce) begin
         bucket_reg <= bucket_next;
      end
   end

   // Pause request held until next refill; a new excess wins
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pause_reg <= 1'b0;
      end else if (ce) begin
         if (take && !ok) begin
            pause_reg <= 1'b1;
         end else if (tick) begin
            pause_reg <= 1'b0;
         end
      end
   end

   assign pause = pause_reg;
endmodule
`default_nettype wire

/* File: src/oicq_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "oicq_regs.svh"
// Behaviour
// - Default policy puts packets in best effort
// - VLAN policy classifies on priority bits
// - DSCP policy classifies on DSCP bits
// - Mixed policy uses top definition's field only
// - Filter policy treated as best effort
// - Local packets on network ports get control
// - Sixteen classes: eight forwarding, two profiles
// - Three queues, four thresholds, class map
// - Default map per table, configurable per type
// - One drop counter per class mapping
// - Over threshold: drop and count
// - Strict priority, queue zero first
// - Within a queue no class distinction
// - Priority acts when bus is oversubscribed
// - Per-port rate limit, excess dropped, pause
module oicq_top
   import oicq_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        pkt_valid,
   output logic             pkt_ready,
   input  wire logic [1:0]  pkt_port,
   input  wire logic        pkt_net,
   input  wire logic        pkt_local,
   input  wire logic [2:0]  pkt_pcp,
   input  wire logic        pkt_dei,
   input  wire logic [5:0]  pkt_dscp,
   input  wire logic [31:0] pkt_data,
   output logic [3:0]       pause_req,
   output logic             bus_valid,
   input  wire logic        bus_ready,
   output logic [31:0]      bus_data,
   output logic [1:0]       bus_queue,
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////
   // Functions
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] base,
                                input int         i);
      return a == 8'(base + 8'(4 * i));
   endfunction

   // Priority code plus drop bit to class index
   function automatic oicq_cls_t cls_of(input logic [2:0] prio,
                                        input logic       out_prof);
      return {~prio, out_prof};
   endfunction

   function automatic logic [15:0] inc_sat(input logic [15:0] v);
      return (v == `OICQ_CNT_MAX) ? v : 16'(v + 16'h0001);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0] ctrl_reg;
   logic [31:0] status_reg;
   logic [31:0] mask_reg;
   logic [31:0] policy_reg [`OICQ_PORTS];
   logic [31:0] map_reg    [6];
   logic [31:0] thr_reg    [`OICQ_QUEUES];
   logic [31:0] rate_reg   [`OICQ_PORTS];
   logic [15:0] cnt_reg    [`OICQ_CLASSES];
   logic [31:0] rd_mux;
   logic [31:0] status_next;
   logic [3:0]  ev;
   logic        en;
   logic        wr;

   assign en = ctrl_reg[`OICQ_CTRL_EN];
   assign wr = reg_wr && ce;

   // Configuration writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_reg <= `OICQ_CTRL_RST;
         mask_reg <= 32'h0000_0000;
         for (int i = 0; i < `OICQ_PORTS; i++) begin
            policy_reg[i] <= 32'h0000_0000;
            rate_reg[i] <= `OICQ_RATE_RST;
         end
         for (int i = 0; i < 3; i++) begin
            map_reg[2 * i] <= `OICQ_MAP_LO_RST;
            map_reg[2 * i + 1] <= `OICQ_MAP_HI_RST;
            thr_reg[i] <= `OICQ_THR_RST;
         end
      end else if (wr) begin
         if (reg_addr == `OICQ_CTRL) ctrl_reg <= reg_wdata;
         if (reg_addr == `OICQ_MASK) mask_reg <= reg_wdata;
         for (int i = 0; i < `OICQ_PORTS; i++) begin
            if (hit(reg_addr, `OICQ_POLICY0, i)) policy_reg[i] <= reg_wdata;
            if (hit(reg_addr, `OICQ_RATE0, i)) rate_reg[i] <= reg_wdata;
         end
         for (int i = 0; i < 6; i++) begin
            if (hit(reg_addr, `OICQ_MAP0, i)) map_reg[i] <= reg_wdata;
         end
         for (int i = 0; i < `OICQ_QUEUES; i++) begin
            if (hit(reg_addr, `OICQ_THR0, i)) thr_reg[i] <= reg_wdata;
         end
      end
   end

   // Sticky status, write one to clear; a new event wins
   always_comb begin
      status_next = status_reg;
      if (wr && reg_addr == `OICQ_STATUS) begin
         status_next = status_reg & ~reg_wdata;
      end
      status_next[3:0] = status_next[3:0] | ev;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         status_reg <= 32'h0000_0000;
      end else if (ce) begin
         status_reg <= status_next;
      end
   end

   assign irq = |(status_reg & mask_reg);

   ////////////////////////////////////////////////////////////////////
   // Queue state
   logic [4:0] fill_reg [`OICQ_QUEUES];
   logic [3:0] head_reg [`OICQ_QUEUES];
   logic [3:0] tail_reg [`OICQ_QUEUES];

   // Read mux; unmapped addresses return zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (reg_addr == `OICQ_CTRL) rd_mux = ctrl_reg;
      if (reg_addr == `OICQ_STATUS) rd_mux = status_reg;
      if (reg_addr == `OICQ_MASK) rd_mux = mask_reg;
      if (reg_addr == `OICQ_OCC) begin
         rd_mux = {8'h00, 3'h0, fill_reg[2], 3'h0, fill_reg[1],
                   3'h0, fill_reg[0]};
      end
      for (int i = 0; i < `OICQ_PORTS; i++) begin
         if (hit(reg_addr, `OICQ_POLICY0, i)) rd_mux = policy_reg[i];
         if (hit(reg_addr, `OICQ_RATE0, i)) rd_mux = rate_reg[i];
      end
      for (int i = 0; i < 6; i++) begin
         if (hit(reg_addr, `OICQ_MAP0, i)) rd_mux = map_reg[i];
      end
      for (int i = 0; i < `OICQ_QUEUES; i++) begin
         if (hit(reg_addr, `OICQ_THR0, i)) rd_mux = thr_reg[i];
      end
      for (int i = 0; i < `OICQ_CLASSES; i++) begin
         if (hit(reg_addr, `OICQ_CNT0, i)) rd_mux = {16'h0000, cnt_reg[i]};
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Rate limiting ahead of classification
   logic [7:0] tick_cnt_reg;
   logic       tick;
   logic [3:0] rate_ok;
   logic       acc;

   assign pkt_ready = ce;
   assign acc = pkt_valid && ce && en;
   assign tick = tick_cnt_reg == 8'(`OICQ_REFRESH_CYC - 1);

   // Common refill tick for all buckets
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tick_cnt_reg <= 8'h00;
      end else if (ce) begin
         tick_cnt_reg <= tick ? 8'h00 : 8'(tick_cnt_reg + 8'h01);
      end
   end

   for (genvar g = 0; g < `OICQ_PORTS; g++) begin : g_rate
      oicq_rate u_rate (
         .ref_clk (ref_clk),
         .reset   (reset),
         .ce      (ce),
         .tick    (tick),
         .rate    (rate_reg[g][7:0]),
         .burst   (rate_reg[g][15:8]),
         .take    (acc && pkt_port == 2'(g)),
         .ok      (rate_ok[g]),
         .pause   (pause_req[g])
      );
   end

   ////////////////////////////////////////////////////////////////////
   // Classification
   oicq_mode_t mode;
   oicq_cls_t  cls;
   logic [1:0] map_sel;
   logic [3:0] entry;
   oicq_qid_t  qsel;
   logic [4:0] level;
   logic       top_dscp;

   always_comb begin
      mode = oicq_mode_t'(policy_reg[pkt_port][2:0]);
      top_dscp = policy_reg[pkt_port][`OICQ_POL_TOPDSCP];
      cls = `OICQ_CLS_BEST;
      map_sel = 2'd0;
      unique case (mode)
         MODE_DEFAULT: cls = `OICQ_CLS_BEST;
         MODE_FILTER:  cls = `OICQ_CLS_BEST;
         MODE_VLAN: begin
            cls = cls_of(pkt_pcp, pkt_dei);
            map_sel = 2'd1;
         end
         MODE_DSCP: begin
            cls = cls_of(pkt_dscp[5:3], pkt_dscp[1]);
            map_sel = 2'd2;
         end
         MODE_MIXED: begin
            // Only the top definition's field counts
            cls = top_dscp ? cls_of(pkt_dscp[5:3], pkt_dscp[1])
                           : cls_of(pkt_pcp, pkt_dei);
            map_sel = top_dscp ? 2'd2 : 2'd1;
         end
         default: cls = `OICQ_CLS_BEST;
      endcase
      if (ctrl_reg[`OICQ_CTRL_NETCTL] && pkt_net && pkt_local) begin
         cls = `OICQ_CLS_NETCTL;
      end
   end

   // Class to queue and threshold index, per classification type
   always_comb begin
      entry = map_reg[{map_sel, cls[3]}][{cls[2:0], 2'b00} +: 4];
      // Unused queue code folds onto queue zero
      qsel = (entry[3:2] == 2'd3) ? 2'd0 : entry[3:2];
      level = thr_reg[qsel][{entry[1:0], 3'b000} +: 5];
   end

   ////////////////////////////////////////////////////////////////////
   // Admission
   logic admit;
   logic drop_ev;
   logic rate_drop;

   assign rate_drop = acc && !rate_ok[pkt_port];
   assign admit = acc && rate_ok[pkt_port] && fill_reg[qsel] < level
                  && fill_reg[qsel] < `OICQ_QDEPTH;
   assign drop_ev = acc && rate_ok[pkt_port] && !admit;

   always_comb begin
      ev = 4'h0;
      ev[`OICQ_EV_RATE] = rate_drop;
      if (drop_ev) ev[qsel] = 1'b1;
   end

   // One saturating counter per class mapping
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int i = 0; i < `OICQ_CLASSES; i++) begin
            cnt_reg[i] <= 16'h0000;
         end
      end else if (drop_ev) begin
         cnt_reg[cls] <= inc_sat(cnt_reg[cls]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Scheduling
   logic       rd_issue;
   logic       rd_pend_reg;
   oicq_qid_t  sel;
   logic       any;
   logic       bus_valid_reg;
   logic [1:0] bus_queue_reg;
   logic [5:0] waddr;
   logic [5:0] raddr;

   // Lowest-numbered nonempty queue wins; class is gone by now
   always_comb begin
      sel = 2'd0;
      if (fill_reg[0] == 5'h00) begin
         sel = (fill_reg[1] != 5'h00) ? 2'd1 : 2'd2;
      end
      any = fill_reg[0] != 5'h00 || fill_reg[1] != 5'h00
            || fill_reg[2] != 5'h00;
   end

   // Bus back-pressure makes queues fill, so priority decides
   assign rd_issue = ce && en && any && !bus_valid_reg
                     && !rd_pend_reg;
   assign waddr = {qsel, tail_reg[qsel]};
   assign raddr = {sel, head_reg[sel]};

   // FIFO pointers and fills per queue
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int q = 0; q < `OICQ_QUEUES; q++) begin
            fill_reg[q] <= 5'h00;
            head_reg[q] <= 4'h0;
            tail_reg[q] <= 4'h0;
         end
      end else begin
         for (int q = 0; q < `OICQ_QUEUES; q++) begin
            if (admit && qsel == 2'(q)) begin
               tail_reg[q] <= 4'(tail_reg[q] + 4'h1);
            end
            if (rd_issue && sel == 2'(q)) begin
               head_reg[q] <= 4'(head_reg[q] + 4'h1);
            end
            fill_reg[q] <= 5'(fill_reg[q]
                              + 5'(admit && qsel == 2'(q))
                              - 5'(rd_issue && sel == 2'(q)));
         end
      end
   end

   // Output stage, one packet in flight
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_pend_reg <= 1'b0;
         bus_valid_reg <= 1'b0;
         bus_queue_reg <= 2'd0;
      end else if (ce) begin
         rd_pend_reg <= rd_issue;
         if (rd_issue) bus_queue_reg <= sel;
         if (rd_pend_reg) begin
            bus_valid_reg <= 1'b1;
         end else if (bus_ready) begin
            bus_valid_reg <= 1'b0;
         end
      end
   end

   assign bus_valid = bus_valid_reg;
   assign bus_queue = bus_queue_reg;

   oicq_mem u_mem (
      .ref_clk (ref_clk),
      .reset   (reset),
      .we      (admit),
      .waddr   (waddr),
      .wdata   (pkt_data),
      .re      (rd_issue),
      .raddr   (raddr),
      .rdata   (bus_data)
   );

   ////////////////////////////////////////////////////////////////////
   // Assertions
   logic [15:0] cnt_sel;
   assign cnt_sel = cnt_reg[cls];

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_issue;
      rd_issue ##1 ce;
   endsequence
   sequence s_present;
      bus_valid && bus_queue == $past(bus_queue);
   endsequence

   a_default_best: assert property (
      acc && mode == MODE_DEFAULT && !(pkt_net && pkt_local)
      |-> cls == 4'hf) else $error("default policy not best effort");
   a_vlan_class: assert property (
      acc && mode == MODE_VLAN && !(pkt_net && pkt_local)
      |-> cls == {~pkt_pcp, pkt_dei}) else $error("vlan class wrong");
   a_dscp_class: assert property (
      acc && mode == MODE_DSCP && !(pkt_net && pkt_local)
      |-> cls == {~pkt_dscp[5:3], pkt_dscp[1]}) else $error("dscp class");
   a_mixed_field: assert property (
      acc && mode == MODE_MIXED && !top_dscp && !(pkt_net && pkt_local)
      |-> cls == {~pkt_pcp, pkt_dei} && map_sel == 2'd1)
      else $error("mixed policy used wrong field");
   a_filter_best: assert property (
      acc && mode == MODE_FILTER && !(pkt_net && pkt_local)
      |-> cls == 4'hf) else $error("filter policy not best effort");
   a_netctl_class: assert property (
      acc && ctrl_reg[1] && pkt_net && pkt_local |-> cls == 4'h0)
      else $error("network control not recognised");
   a_admit_level: assert property (
      admit |-> fill_reg[qsel] < level && qsel != 2'd3)
      else $error("admitted at or above level");
   a_drop_count: assert property (
      drop_ev && cnt_sel != 16'hffff
      |=> cnt_reg[$past(cls)] == 16'($past(cnt_sel) + 16'h0001))
      else $error("drop counter not incremented");
   a_strict_prio: assert property (
      rd_issue |-> fill_reg[sel] != 5'h00
                   && (sel == 2'd0 || fill_reg[0] == 5'h00)
                   && (sel != 2'd2 || fill_reg[1] == 5'h00))
      else $error("queue served out of priority order");
   a_bus_present: assert property (
      s_issue |=> s_present) else $error("issued read not presented");
endmodule
`default_nettype wire

/* File: verification/oicq_fwd_sink.sv */
`timescale 1ns/100ps
`default_nettype none
module oicq_fwd_sink (
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic hold,
   input  wire logic slow,
   output logic      bus_ready
);
   logic [1:0] beat_reg;

   ////////////////////////////////////////////////////////////////////////
   // Slow mode takes one cycle in four, so words pile up in the queues
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         beat_reg  <= 2'h0;
         bus_ready <= 1'b0;
      end else begin
         beat_reg  <= beat_reg + 2'h1;
         bus_ready <= !hold && (!slow || beat_reg == 2'h3);
      end
   end
endmodule
`default_nettype wire

/* File: verification/oicq_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "oicq_regs.svh"
module oicq_top_tb
   import oicq_pkg::*;
;
   logic        ref_clk, reset, ce, reg_wr, reg_rd, rd_d;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, pkt_data, bus_data, seed;
   logic        pkt_valid, pkt_ready, pkt_net, pkt_local, pkt_dei;
   logic [1:0]  pkt_port, bus_queue;
   logic [2:0]  pkt_pcp;
   logic [5:0]  pkt_dscp;
   logic [3:0]  pause_req;
   logic        bus_valid, bus_ready, irq, hold, slow;
   logic [33:0] w;
   logic [31:0] rq[$];
   logic [33:0] ws[$];
   logic [31:0] eq[3][$];
   logic [4:0]  fill[3];
   logic [15:0] cnt[16];
   logic [2:0]  st;
   logic [3:0]  pol[4];
   int          fails, checks, i;

   oicq_top uut (.ref_clk(ref_clk), .reset(reset), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid),
      .pkt_ready(pkt_ready), .pkt_port(pkt_port), .pkt_net(pkt_net),
      .pkt_local(pkt_local), .pkt_pcp(pkt_pcp), .pkt_dei(pkt_dei),
      .pkt_dscp(pkt_dscp), .pkt_data(pkt_data), .pause_req(pause_req),
      .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_data(bus_data),
      .bus_queue(bus_queue), .irq(irq));
   oicq_fwd_sink sink (.ref_clk(ref_clk), .reset(reset), .hold(hold),
      .slow(slow), .bus_ready(bus_ready));

   always #2.5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h8020_0003 : s >> 1;
   endfunction
   // Expected class; local traffic on a network port wins over policy
   function automatic oicq_cls_t cls_of(input logic [3:0] p,
      input logic nc, input logic [2:0] pcp, input logic dei,
      input logic [5:0] ds);
      if (nc) return `OICQ_CLS_NETCTL;
      case (p[2:0])
         3'h1: return {~pcp, dei};
         3'h2: return {~ds[5:3], ds[1]};
         3'h3: return p[3] ? {~ds[5:3], ds[1]} : {~pcp, dei};
         default: return `OICQ_CLS_BEST;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Each access leaves a free cycle, so a strobe is never set twice
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic setpol(input logic [1:0] p, input logic [3:0] v);
      pol[p] = v;
      wr(`OICQ_POLICY0 + {4'h0, p, 2'b00}, {28'h0, v});
   endtask
   // how: 0 through admission model, 1 straight to output, 2 no model
   task automatic send(input logic [1:0] p, input logic nc,
      input logic [1:0] how);
      oicq_cls_t c;
      oicq_qid_t q;
      logic [4:0] lvl;
      seed = lfsr(seed);
      pkt_valid <= 1'b1;
      pkt_port <= p;
      // Local but off a network port, or the reverse, stays ordinary
      pkt_net <= nc | seed[10];
      pkt_local <= nc | !seed[10];
      pkt_pcp <= seed[2:0];
      pkt_dei <= seed[3];
      pkt_dscp <= seed[9:4];
      pkt_data <= seed;
      c = cls_of(pol[p], nc, seed[2:0], seed[3], seed[9:4]);
      q = c[3] ? 2'd0 : (c[2] ? 2'd1 : 2'd2);
      lvl = {1'b0, (c[3] ? ~c[2:1] : ~c[1:0]), 2'b00} + 5'h04;
      if (how == 2'd1) ws.push_back({q, seed});
      else if (how == 2'd0 && fill[q] < lvl) begin
         eq[q].push_back(seed);
         fill[q]++;
      end else if (how == 2'd0) begin
         cnt[c]++;
         st[q] = 1'b1;
      end
      @(posedge ref_clk);
   endtask
   task automatic idle();
      pkt_valid <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic drain();
      for (i = 0; i < 600 && ws.size() > 0; i++) @(posedge ref_clk);
      chk(ws.size(), 32'h0);
   endtask
   task automatic final_report();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Read data and forwarded words against the oldest note
   always @(posedge ref_clk) begin
      if (rd_d) chk(reg_rdata, rq.pop_front());
      rd_d <= reg_rd;
      if (bus_valid && bus_ready && ce) begin
         w = ws.pop_front();
         chk(bus_data, w[31:0]);
         chk({30'h0, bus_queue}, {30'h0, w[33:32]});
      end
   end

   // Whole run is under 600 cycles
   initial begin
      repeat (6000) @(posedge ref_clk);
      fails++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      ce = 1'b1;
      {reg_wr, reg_rd, pkt_valid, pkt_net, pkt_local} = 5'h0;
      {reg_addr, reg_wdata, pkt_data} = 72'h0;
      {pkt_port, pkt_pcp, pkt_dei, pkt_dscp} = 12'h0;
      {hold, slow} = 2'b10;
      {fails, checks, st} = 0;
      seed = 32'h0001_5936;
      for (i = 0; i < 16; i++) cnt[i] = 16'h0;
      for (i = 0; i < 4; i++) pol[i] = 4'h0;
      for (i = 0; i < 3; i++) fill[i] = 5'h0;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      // Buckets start empty, so this packet is discarded
      send(2'd3, 1'b0, 2'd2);
      idle();
      #1;
      chk({28'h0, pause_req}, 32'h8);
      chk({31'h0, pkt_ready}, 32'h1);
      @(posedge ref_clk);
      rd(`OICQ_STATUS, 32'h8);
      wr(`OICQ_MASK, 32'h8);
      #1 chk({31'h0, irq}, 32'h1);
      @(posedge ref_clk);
      wr(`OICQ_STATUS, 32'h8);
      #1 chk({31'h0, irq}, 32'h0);
      @(posedge ref_clk);
      // Reset values, and an unmapped place that ignores writes
      rd(`OICQ_CTRL, `OICQ_CTRL_RST);
      rd(`OICQ_MAP0 + 8'h08, `OICQ_MAP_LO_RST);
      rd(`OICQ_MAP0 + 8'h14, `OICQ_MAP_HI_RST);
      rd(`OICQ_THR0 + 8'h08, `OICQ_THR_RST);
      rd(`OICQ_RATE0, `OICQ_RATE_RST);
      wr(8'hfc, 32'hffff_ffff);
      rd(8'hfc, 32'h0);
      for (i = 0; i < 4; i++) wr(`OICQ_RATE0 + 8'(4 * i), 32'h0000_ffff);
      repeat (200) @(posedge ref_clk);
      #1 chk({28'h0, pause_req}, 32'h0);
      @(posedge ref_clk);
      // Queue 2 word parks at the stalled output, the rest pile up
      setpol(2'd1, 4'h1);
      setpol(2'd2, 4'h2);
      setpol(2'd3, 4'hb);
      send(2'd0, 1'b1, 2'd1);
      idle();
      repeat (5) @(posedge ref_clk);
      repeat (6) send(2'd0, 1'b0, 2'd0);
      idle();
      setpol(2'd0, 4'h3);
      for (i = 0; i < 32; i++)
         send(2'(i), i == 9, 2'd0);
      idle();
      setpol(2'd0, 4'h4);
      send(2'd0, 1'b0, 2'd0);
      idle();
      setpol(2'd0, 4'h5);
      send(2'd0, 1'b0, 2'd0);
      idle();
      rd(`OICQ_OCC,
         {11'h0, fill[2], 3'h0, fill[1], 3'h0, fill[0]});
      for (i = 0; i < 16; i++)
         rd(`OICQ_CNT0 + 8'(4 * i), {16'h0, cnt[i]});
      rd(`OICQ_STATUS, {29'h0, st});
      wr(`OICQ_MASK, 32'h7);
      #1 chk({31'h0, irq}, {31'h0, |st});
      @(posedge ref_clk);
      wr(`OICQ_STATUS, {29'h0, st});
      rd(`OICQ_STATUS, 32'h0);
      #1 chk({31'h0, irq}, 32'h0);
      @(posedge ref_clk);
      // Strict priority: queue 0 empties before 1, then 2
      for (i = 0; i < 3; i++)
         while (eq[i].size() > 0) ws.push_back({2'(i), eq[i].pop_front()});
      hold <= 1'b0;
      slow <= 1'b1;
      drain();
      rd(`OICQ_OCC, 32'h0);
      // Back-to-back control traffic under a prompt sink keeps order
      slow <= 1'b0;
      repeat (8) send(2'd1, 1'b1, 2'd1);
      // Clock enable low: the offered word is ignored and nothing moves
      ce <= 1'b0;
      send(2'd1, 1'b1, 2'd2);
      idle();
      #1 chk({31'h0, pkt_ready}, 32'h0);
      repeat (3) @(posedge ref_clk);
      ce <= 1'b1;
      drain();
      // A word taken while frozen would surface here with no note
      repeat (8) @(posedge ref_clk);
      final_report();
   end
endmodule
`default_nettype wire
